/* File: design/cds_pkg.sv */
// constants for the channel divider and status register bank
// assumes a register access port driven by an i2c front end on core_clk
package cds_pkg;
	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] CH1_DIV_OFS = 8'h15;
	localparam logic [7:0] CH2_DIV_OFS = 8'h16;
	localparam logic [7:0] CH3_DIV_OFS = 8'h17;
	localparam logic [7:0] STATUS_OFS  = 8'h18;
	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int FIN_LSB   = 12;
	localparam int FIN_W     = 4;
	localparam int FREF_LSB  = 0;
	localparam int FREF_W    = 10;
	localparam int ECH_LSB   = 14;
	localparam int UR_BIT    = 13;
	localparam int OR_BIT    = 12;
	localparam int WD_BIT    = 11;
	localparam int AHE_BIT   = 10;
	localparam int ALE_BIT   = 9;
	localparam int ZC_BIT    = 8;
	localparam int RDY_BIT   = 6;
	localparam int UNR0_BIT  = 3;
	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [15:0] DIV_RST    = 16'h0000;
	localparam logic [15:0] STATUS_RST = 16'h0000;
	localparam logic [9:0]  FREF_RST   = 10'h000;
endpackage : cds_pkg

/* File: design/cds_ref_div.sv */
// reference clock enable generator for one channel
// assumes divider value is static while in use; zero is treated as stop
module cds_ref_div (
	input  wire logic       core_clk,
	input  wire logic       rst_b,
	input  wire logic [9:0] div_val,
	output logic            ref_tick
);
	logic [9:0] cnt_q;

	// ----------------------------------------------------------------
	// divide core clock by div_val
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_q    <= cds_pkg::FREF_RST;
			ref_tick <= 1'b0;
		end else if (div_val == 10'h000) begin
			// reserved code: no defined ratio, hold still
			cnt_q    <= cds_pkg::FREF_RST;
			ref_tick <= 1'b0;
		end else if (cnt_q >= div_val - 10'h001) begin
			cnt_q    <= cds_pkg::FREF_RST;
			ref_tick <= 1'b1;
		end else begin
			cnt_q    <= cnt_q + 10'h001;
			ref_tick <= 1'b0;
		end
	end
endmodule : cds_ref_div

/* File: design/cds_regs.sv */
// channel 1..3 clock divider registers and converter status register
// assumes a synchronous register port from the i2c front end; one access per pulse
// Functional notes
// - divider bits 15:12 hold sensor input divider; zero reserved
// - divider bits 9:0 hold reference divider; ref clock = clk / value
// - status bits 15:14 name the channel that raised the error
// - errors latch until status read or source channel upper result read
// - under-range event sets status bit 13
// - over-range event sets status bit 12
// - status read clears error flags after the read
// - result ready bit 6 rises on new result, all active channels in sequence
// - unread bits show per channel results not yet fetched
module cds_regs (
	input  wire logic        core_clk,
	input  wire logic        rst_b,
	input  wire logic [7:0]  reg_addr,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [15:0] reg_wdata,
	output logic      [15:0] reg_rdata,
	input  wire logic        evt_valid,
	input  wire logic [1:0]  evt_chan,
	input  wire logic        evt_under,
	input  wire logic        evt_over,
	input  wire logic        evt_wd,
	input  wire logic        evt_amp_hi,
	input  wire logic        evt_amp_lo,
	input  wire logic        evt_zero,
	input  wire logic        result_new,
	input  wire logic        seq_mode,
	input  wire logic [3:0]  active_chans,
	input  wire logic [3:0]  result_rd,
	output logic      [3:0]  sensor_input_div_ch1,
	output logic      [3:0]  sensor_input_div_ch2,
	output logic      [3:0]  sensor_input_div_ch3,
	output logic      [9:0]  reference_div_ch1,
	output logic      [9:0]  reference_div_ch2,
	output logic      [9:0]  reference_div_ch3,
	output logic      [3:0]  ref_tick
);
	logic [15:0] div_q [1:3];
	logic [1:0]  error_source_channel_q;
	logic [5:0]  err_q;
	logic        result_ready_flag_q;
	logic [3:0]  unread_q;
	logic [3:0]  seq_got_q;
	logic        status_rd;
	logic        src_rd;
	logic [5:0]  err_evt;
	logic [3:0]  chan_onehot;
	logic [3:0]  seq_got_d;
	logic [15:0] status_word;

	function automatic logic [3:0] cds_onehot(input logic [1:0] c);
		cds_onehot = 4'h1 << c;
	endfunction : cds_onehot

	function automatic logic [3:0] cds_fin(input logic [15:0] w);
		cds_fin = w[cds_pkg::FIN_LSB +: cds_pkg::FIN_W];
	endfunction : cds_fin

	function automatic logic [9:0] cds_fref(input logic [15:0] w);
		cds_fref = w[cds_pkg::FREF_LSB +: cds_pkg::FREF_W];
	endfunction : cds_fref

	// ----------------------------------------------------------------
	// access decode
	// ----------------------------------------------------------------
	assign status_rd   = reg_rd && (reg_addr == cds_pkg::STATUS_OFS);
	// result_rd bit set means upper result word of that channel read
	assign src_rd      = |(result_rd & cds_onehot(error_source_channel_q));
	assign err_evt     = evt_valid ? {evt_under, evt_over, evt_wd, evt_amp_hi, evt_amp_lo,
		evt_zero} : 6'h00;
	assign chan_onehot = cds_onehot(evt_chan);

	// ----------------------------------------------------------------
	// divider registers
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			div_q[1] <= cds_pkg::DIV_RST;
			div_q[2] <= cds_pkg::DIV_RST;
			div_q[3] <= cds_pkg::DIV_RST;
		end else if (reg_wr) begin
			// reserved bits stored as written; host keeps them zero
			unique case (reg_addr)
				cds_pkg::CH1_DIV_OFS: div_q[1] <= reg_wdata;
				cds_pkg::CH2_DIV_OFS: div_q[2] <= reg_wdata;
				cds_pkg::CH3_DIV_OFS: div_q[3] <= reg_wdata;
				default: ;
			endcase
		end
	end

	assign sensor_input_div_ch1 = cds_fin(div_q[1]);
	assign sensor_input_div_ch2 = cds_fin(div_q[2]);
	assign sensor_input_div_ch3 = cds_fin(div_q[3]);
	assign reference_div_ch1    = cds_fref(div_q[1]);
	assign reference_div_ch2    = cds_fref(div_q[2]);
	assign reference_div_ch3    = cds_fref(div_q[3]);

	// ----------------------------------------------------------------
	// reference clock enables, channel 0 divider lives elsewhere
	// ----------------------------------------------------------------
	assign ref_tick[0] = 1'b0;
	cds_ref_div u_ref1 (
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.div_val  (reference_div_ch1),
		.ref_tick (ref_tick[1])
	);
	cds_ref_div u_ref2 (
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.div_val  (reference_div_ch2),
		.ref_tick (ref_tick[2])
	);
	cds_ref_div u_ref3 (
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.div_val  (reference_div_ch3),
		.ref_tick (ref_tick[3])
	);

	// ----------------------------------------------------------------
	// error flags and source channel
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			err_q                  <= 6'h00;
			error_source_channel_q <= 2'b00;
		end else begin
			// new event wins over a clear in the same cycle
			if (status_rd || src_rd) begin
				err_q <= err_evt;
			end else begin
				err_q <= err_q | err_evt;
			end
			if (|err_evt) begin
				error_source_channel_q <= evt_chan;
			end
		end
	end

	// ----------------------------------------------------------------
	// result ready and unread conversions
	// ----------------------------------------------------------------
	always_comb begin
		seq_got_d = seq_got_q;
		if (result_new) begin
			seq_got_d = seq_got_q | chan_onehot;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			result_ready_flag_q <= 1'b0;
			seq_got_q           <= 4'h0;
		end else begin
			// sequential mode waits for every active channel
			if (result_new && (!seq_mode || ((seq_got_d & active_chans) == active_chans))) begin
				result_ready_flag_q <= 1'b1;
				seq_got_q           <= 4'h0;
			end else begin
				seq_got_q <= seq_got_d;
				if (status_rd) begin
					result_ready_flag_q <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			unread_q <= 4'h0;
		end else begin
			unread_q <= (unread_q & ~result_rd) | (result_new ? chan_onehot : 4'h0);
		end
	end

	// ----------------------------------------------------------------
	// status word assembly; reserved bits 7 and 5:4 stay zero
	// ----------------------------------------------------------------
	always_comb begin
		status_word = cds_pkg::STATUS_RST;
		status_word[cds_pkg::ECH_LSB +: 2] = error_source_channel_q;
		status_word[cds_pkg::UR_BIT]       = err_q[5];
		status_word[cds_pkg::OR_BIT]       = err_q[4];
		status_word[cds_pkg::WD_BIT]       = err_q[3];
		status_word[cds_pkg::AHE_BIT]      = err_q[2];
		status_word[cds_pkg::ALE_BIT]      = err_q[1];
		status_word[cds_pkg::ZC_BIT]       = err_q[0];
		status_word[cds_pkg::RDY_BIT]      = result_ready_flag_q;
		// channel 0 sits highest, so the unread bits run backwards
		for (int i = 0; i < 4; i++) begin
			status_word[cds_pkg::UNR0_BIT - i] = unread_q[i];
		end
	end

	// ----------------------------------------------------------------
	// read mux, registered; unmapped reads return zero
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			reg_rdata <= cds_pkg::STATUS_RST;
		end else if (reg_rd) begin
			unique case (reg_addr)
				cds_pkg::CH1_DIV_OFS: reg_rdata <= div_q[1];
				cds_pkg::CH2_DIV_OFS: reg_rdata <= div_q[2];
				cds_pkg::CH3_DIV_OFS: reg_rdata <= div_q[3];
				cds_pkg::STATUS_OFS: reg_rdata <= status_word;
				default: reg_rdata <= 16'h0000;
			endcase
		end
	end
endmodule : cds_regs

/* File: tb/cds_regs_chk.sv */
// port checker for the divider and status register bank
// assumes binding onto cds_regs, single clock, quiet strobe one cycle apart
module cds_regs_chk (
	input wire logic        core_clk,
	input wire logic        rst_b,
	input wire logic [7:0]  reg_addr,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [15:0] reg_wdata,
	input wire logic [15:0] reg_rdata,
	input wire logic        evt_valid,
	input wire logic [1:0]  evt_chan,
	input wire logic        evt_under,
	input wire logic        evt_over,
	input wire logic        result_new,
	input wire logic        seq_mode,
	input wire logic [3:0]  result_rd,
	input wire logic [3:0]  sensor_input_div_ch1,
	input wire logic [9:0]  reference_div_ch1
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	wire       rs    = reg_rd && reg_addr == 8'h18;
	wire       w1    = reg_wr && reg_addr == 8'h15;
	wire [3:0] w_fin = reg_wdata[15:12];
	wire [9:0] w_ref = reg_wdata[9:0];
	sequence s_quiet; !evt_valid && result_rd == 4'h0; endsequence
	sequence s_ur; evt_valid && evt_under && !rs; endsequence
	// flags are only looked at two cycles on, after one idle cycle
	sequence s_then_rd; (s_quiet and !rs) ##1 (rs and s_quiet); endsequence
	AST_FIELDS: assert property (w1 |=> {sensor_input_div_ch1, reference_div_ch1} ==
		{$past(w_fin), $past(w_ref)}) else $error("divider fields not loaded");
	AST_UR_SET: assert property (s_ur ##1 s_then_rd |=> reg_rdata[13])
		else $error("under-range flag missing");
	AST_OR_SET: assert property (evt_valid && evt_over && !rs ##1 s_then_rd |=> reg_rdata[12])
		else $error("over-range flag missing");
	AST_CHAN: assert property (evt_valid && (evt_under || evt_over) && !rs ##1 s_then_rd |=>
		reg_rdata[15:14] == $past(evt_chan, 3)) else $error("wrong error channel");
	AST_SRC_CLR: assert property ((s_ur and evt_chan == 2'h2) ##1 (s_quiet and !rs)
		##1 (result_rd == 4'h4 && !evt_valid && !rs) ##1 s_then_rd |=> !reg_rdata[13])
		else $error("source result read did not clear");
	AST_READ_CLR: assert property ((rs and s_quiet) ##1 s_then_rd |=>
		reg_rdata[13:12] == 2'b00) else $error("flags survived a status read");
	AST_RDY: assert property (result_new && !seq_mode && !rs ##1 s_then_rd |=> reg_rdata[6])
		else $error("result ready missing");
	AST_UNREAD: assert property (result_new && evt_chan == 2'h0 && result_rd == 4'h0
		##1 s_then_rd |=> reg_rdata[3]) else $error("unread bit missing");
	AST_RESET: assert property ($rose(rst_b) |-> reg_rdata == 16'h0000 &&
		sensor_input_div_ch1 == 4'h0 && reference_div_ch1 == 10'h000) else $error("reset values");
endmodule : cds_regs_chk
bind cds_regs cds_regs_chk i_chk (.*);

/* File: tb/cds_host.sv */
// host model on the register port
// assumes calls from one bench process; one access at a time
module cds_host (
	input  wire logic        core_clk,
	output logic      [7:0]  reg_addr,
	output logic             reg_wr,
	output logic             reg_rd,
	output logic      [15:0] reg_wdata,
	input  wire logic [15:0] reg_rdata
);
	timeunit 1ns;
	timeprecision 1ns;
	initial {reg_addr, reg_wr, reg_rd, reg_wdata} = 26'h0000000;
	task automatic acc(input logic [7:0] a, input logic w, input logic [15:0] d,
		output logic [15:0] q);
		@(posedge core_clk);
		reg_addr  <= a;
		reg_wr    <= w;
		reg_rd    <= !w;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr    <= 1'b0;
		reg_rd    <= 1'b0;
		reg_wdata <= ~d;
		#1 q = reg_rdata;
	endtask : acc
	// sensors taken as fast, so input divider kept at two or more
	task automatic cfg(input logic [7:0] a, input logic [15:0] v, output logic [15:0] q);
		q = {(v[15:12] < 4'h2) ? 4'h2 : v[15:12], 2'b00,
			(v[9:0] == 10'h000) ? 10'h001 : v[9:0]};
		acc(a, 1'b1, q, v);
	endtask : cfg
endmodule : cds_host

/* File: tb/test_channel_divider_status_regs.sv */
// bench for the divider and status register bank
// assumes host model drives the register port, this module the event inputs
module test_channel_divider_status_regs;
	timeunit 1ns;
	timeprecision 1ns;
	logic        core_clk = 1'b0;
	logic        rst_b = 1'b0;
	logic        seq_mode = 1'b0;
	logic [7:0]  reg_addr;
	logic        reg_wr, reg_rd, evt_valid, evt_under, evt_over, evt_wd, evt_amp_hi;
	logic        evt_amp_lo, evt_zero, result_new;
	logic [15:0] reg_wdata, reg_rdata, q, e, st;
	logic [1:0]  evt_chan, c;
	logic [3:0]  active_chans, result_rd, ref_tick, unread, sensor_input_div_ch1;
	logic [3:0]  sensor_input_div_ch2, sensor_input_div_ch3;
	logic [9:0]  reference_div_ch1, reference_div_ch2, reference_div_ch3;
	int          errors = 0, n_checks = 0, cyc = 0, t, t2, t3;
	cds_regs i_dut (.*);
	cds_host i_host (.*);
	always #20 core_clk = ~core_clk;
	task automatic chk(input string n, input logic [15:0] s, input logic [15:0] x);
		n_checks++;
		if (s !== x) begin
			errors++;
			$display("BAD %s expected %h seen %h", n, x, s);
		end
	endtask : chk
	task automatic ev(input logic [1:0] ch, input logic [5:0] k, input logic rn,
		input logic [3:0] rr);
		@(posedge core_clk);
		evt_chan <= ch;
		evt_valid <= |k;
		{evt_under, evt_over, evt_wd, evt_amp_hi, evt_amp_lo, evt_zero} <= k;
		result_new <= rn;
		result_rd <= rr;
		@(posedge core_clk);
		evt_valid <= 1'b0;
		result_new <= 1'b0;
		result_rd <= 4'h0;
	endtask : ev
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : tally_and_finish
	// whole run needs well under a thousand cycles
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			errors++;
			tally_and_finish();
		end
	end
	initial begin
		{evt_valid, evt_under, evt_over, evt_wd, evt_amp_hi, evt_amp_lo, evt_zero} = 7'h00;
		{result_new, evt_chan, result_rd, active_chans, unread} = 15'h00F0;
		t = $urandom(78445);
		repeat (20) @(posedge core_clk);
		rst_b <= 1'b1;
		i_host.acc(8'h18, 1'b1, 16'hFFFF, q);
		for (int a = 8'h14; a <= 8'h19; a++) begin
			i_host.acc(a[7:0], 1'b0, 16'h0000, q);
			chk("reset read", q, 16'h0000);
		end
		chk("idle ticks", {12'h000, ref_tick}, 16'h0000);
		$display("reset test done");
		for (int a = 8'h15; a <= 8'h17; a++) begin
			i_host.cfg(a[7:0], 16'($urandom), e);
			i_host.acc(a[7:0], 1'b0, 16'h0000, q);
			chk("divider", q, e);
		end
		chk("ch3 fields", {sensor_input_div_ch3, 2'b00, reference_div_ch3}, e);
		i_host.cfg(8'h16, 16'h1002, e);
		chk("ch2 fields", {sensor_input_div_ch2, 2'b00, reference_div_ch2}, e);
		i_host.cfg(8'h17, 16'h200A, e);
		i_host.cfg(8'h15, 16'h2005, e);
		chk("ch1 fields", {sensor_input_div_ch1, 2'b00, reference_div_ch1}, e);
		repeat (10) @(posedge core_clk);
		t = 0;
		t2 = 0;
		t3 = 0;
		repeat (50) begin
			@(posedge core_clk);
			#1 t += ref_tick[1] + 2 * ref_tick[0];
			t2 += ref_tick[2];
			t3 += ref_tick[3];
		end
		chk("tick count", 16'(t), 16'h000A);
		chk("tick count ch2", 16'(t2), 16'h0019);
		chk("tick count ch3", 16'(t3), 16'h0005);
		$display("divider test done");
		for (int k = 0; k < 6; k++) begin
			c = 2'(k);
			unread |= 4'h8 >> c;
			ev(c, 6'h20 >> k, 1'b1, 4'h0);
			st = {c, 6'h20 >> k, 2'b01, 2'b00, unread};
			i_host.acc(8'h18, 1'b0, 16'h0000, q);
			chk("status", q, st);
			i_host.acc(8'h18, 1'b0, 16'h0000, q);
			chk("status reread", q & 16'h3FFF, {12'h000, unread});
		end
		ev(2'h2, 6'h20, 1'b0, 4'h0);
		ev(2'h0, 6'h00, 1'b0, 4'h4);
		unread &= 4'hD;
		i_host.acc(8'h18, 1'b0, 16'h0000, q);
		chk("source clear", q & 16'h3FFF, {12'h000, unread});
		$display("status test done");
		@(posedge core_clk);
		seq_mode <= 1'b1;
		active_chans <= 4'h5;
		ev(2'h0, 6'h00, 1'b1, 4'h0);
		i_host.acc(8'h18, 1'b0, 16'h0000, q);
		chk("seq partial", q & 16'h3FFF, {12'h000, unread});
		ev(2'h2, 6'h00, 1'b1, 4'h0);
		unread |= 4'h2;
		i_host.acc(8'h18, 1'b0, 16'h0000, q);
		chk("seq complete", q & 16'h3FFF, {8'h00, 2'b01, 2'b00, unread});
		$display("sequence test done");
		tally_and_finish();
	end
endmodule : test_channel_divider_status_regs
